// ==== verilog/scs_sysref_sync.v ====
// Function
// - On every captured SYSREF the divider phase at that moment is stored as a 4-bit read-only code, 0000 in phase.
// - The phase code counts half input-clock cycles of SYSREF delay, 0001 half a cycle up to 1111 seven and a half.
// - An 8-bit read-only counter increments by one on every captured SYSREF.
// - The event counter wraps from 255 to zero instead of saturating.
// - Writing bit 6 of the control register at 0x120 clears the event counter.
// - With sync mode bit 0 a captured SYSREF resets every internal clock divider.
// - In divider-reset mode a SYSREF that forces a divider phase change drops the serial link.
// - With sync mode bit 1 a captured SYSREF leaves all dividers untouched.
// - In timestamp mode SYSREF has no effect on the link state or the signal monitor.
// - In timestamp mode the sample coincident with SYSREF is marked and the mark rides as a control bit.
// - With the I-only bit 5 of the chip mode register at 0 both I and Q are output.
// - With the I-only bit at 1 only I is output and Q is discarded.
// - The timestamp mark is delayed by a programmable 0 to 127 sample clock cycles.
//
// Implementation choice: the Avalon-MM register port.
`include "scs_map.vh"

module scs_sysref_sync #(
  parameter DATA_W = 14,                        // Converter sample width
  parameter ADDR_W = 12                         // Avalon byte address width
) (
  input  wire              clk,                 // Sample clock, 200 MHz
  input  wire              rst,                 // Synchronous reset, active high
  input  wire              ce,                  // Clock enable, freezes all state when low
  input  wire [ADDR_W-1:0] address,             // Avalon byte address
  input  wire              read,                // Avalon read request
  input  wire              write,               // Avalon write request
  input  wire [31:0]       writedata,           // Avalon write data
  input  wire [3:0]        byteenable,          // Avalon byte enables
  output reg  [31:0]       readdata,            // Avalon read data
  output wire              waitrequest,         // Avalon wait request
  input  wire              sysref_capture,      // One-cycle pulse, SYSREF edge captured
  input  wire [3:0]        div_phase,           // Divider phase in half input cycles
  input  wire [DATA_W-1:0] in_i,                // Incoming I sample
  input  wire [DATA_W-1:0] in_q,                // Incoming Q sample
  input  wire              in_valid,            // Incoming sample valid
  output reg  [DATA_W-1:0] out_i,               // Outgoing I sample
  output reg  [DATA_W-1:0] out_q,               // Outgoing Q sample, zero when discarded
  output reg               out_q_en,            // Q component present in output word
  output reg               out_valid,           // Outgoing word valid
  output reg               out_ts_mark,         // Timestamp control bit of output word
  output reg               div_reset,           // Pulse, reset all internal dividers
  output reg               link_drop,           // Pulse, drop the serial link
  output reg               mon_sync,            // Pulse, signal monitor realignment
  output reg  [1:0]        sysref_mode          // SYSREF mode select field for capture logic
);

  localparam DLY_LEN = `SCS_TS_DELAY_MAX;

  // Bus handshake states
  localparam [0:0] BUS_IDLE = 1'b0;
  localparam [0:0] BUS_ACK  = 1'b1;

  // Register storage
  reg [3:0]         phase_reg;
  reg [3:0]         phase_next;
  reg [7:0]         count_reg;
  reg [7:0]         count_next;
  reg               sync_mode_reg;
  reg [7:0]         op_mode_reg;
  reg [6:0]         ts_delay_reg;
  reg [0:0]         bus_state_reg;
  reg [0:0]         bus_state_next;
  reg [DLY_LEN-1:0] mark_line_reg;

  wire [9:0] idx;
  wire       bus_req;
  wire       bus_idle;
  wire       bus_take;
  wire       wr_go;
  wire       wr_ctrl1;
  wire       wr_ts_delay;
  wire       wr_sync_mode;
  wire       wr_op_mode;
  wire       clr_cnt;
  wire       reset_mode;
  wire       phase_moved;
  wire       ts_event;
  wire       ts_tap;
  wire [7:0] ctrl1_rd;
  wire [7:0] rd_byte;

  function [0:0] idx_hit;
    input [9:0] a;
    input [9:0] b;
    begin
      idx_hit = (a == b);
    end
  endfunction

  // Unmapped indices and reserved bits read as zero
  function [7:0] reg_read;
    input [9:0] a;
    input [7:0] ctrl1;
    input [6:0] tsd;
    input [3:0] phase;
    input [7:0] count;
    input       sync;
    input [7:0] op;
    begin
      case (a)
        `SCS_IDX_CTRL1:     reg_read = ctrl1;
        `SCS_IDX_TS_DELAY:  reg_read = {1'b0, tsd};
        `SCS_IDX_PHASE:     reg_read = {4'h0, phase};
        `SCS_IDX_COUNT:     reg_read = count;
        `SCS_IDX_SYNC_MODE: reg_read = {7'h00, sync};
        `SCS_IDX_OP_MODE:   reg_read = op;
        default:            reg_read = 8'h00;
      endcase
    end
  endfunction

  // A clear in the same cycle as a capture restarts the count at one, so no event is lost
  function [7:0] count_step;
    input [7:0] cnt;
    input       cap;
    input       clr;
    begin
      if (cap & clr)
        count_step = 8'h01;
      else if (cap)
        count_step = cnt + 8'h01;
      else if (clr)
        count_step = 8'h00;
      else
        count_step = cnt;
    end
  endfunction

  // Unused low address bits; the map is word aligned
  assign idx      = address[11:2];
  assign bus_req  = read | write;
  assign bus_idle = (bus_state_reg == BUS_IDLE);
  assign bus_take = bus_req & bus_idle;

  // Wait stays high while frozen, else a write could be lost
  assign waitrequest = bus_req & ~(ce & ~bus_idle);

  // A write lands on the edge where waitrequest is seen low
  assign wr_go        = ce & write & ~bus_idle & byteenable[0];
  assign wr_ctrl1     = wr_go & idx_hit(idx, `SCS_IDX_CTRL1);
  assign wr_ts_delay  = wr_go & idx_hit(idx, `SCS_IDX_TS_DELAY);
  assign wr_sync_mode = wr_go & idx_hit(idx, `SCS_IDX_SYNC_MODE);
  assign wr_op_mode   = wr_go & idx_hit(idx, `SCS_IDX_OP_MODE);
  assign clr_cnt      = wr_ctrl1 & writedata[`SCS_CTRL1_CLR_BIT];

  // Timestamp events only exist in timestamp mode
  assign reset_mode  = ~sync_mode_reg;
  assign phase_moved = (div_phase != 4'h0);
  assign ts_event    = sysref_capture & sync_mode_reg;

  // Bit 6 is a self-clearing action, it reads back as zero
  assign ctrl1_rd = {5'h00, sysref_mode, 1'h0};
  assign rd_byte  = reg_read(idx, ctrl1_rd, ts_delay_reg, phase_reg, count_reg, sync_mode_reg, op_mode_reg);

  // Tap zero bypasses the delay line
  assign ts_tap = (ts_delay_reg == 7'h00) ? ts_event : mark_line_reg[ts_delay_reg - 7'h01];

  // One wait cycle per access
  always @* begin
    bus_state_next = bus_state_reg;
    case (bus_state_reg)
      BUS_IDLE: begin
        if (bus_req)
          bus_state_next = BUS_ACK;
      end
      BUS_ACK: begin
        bus_state_next = BUS_IDLE;
      end
      default: begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      bus_state_reg <= BUS_IDLE;
    end else if (ce) begin
      bus_state_reg <= bus_state_next;
    end
  end

  // Loaded as the request is taken, held until the next one
  always @(posedge clk) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (ce & bus_take) begin
      readdata <= read ? {24'h000000, rd_byte} : 32'h0000_0000;
    end
  end

  // Software-written control
  always @(posedge clk) begin
    if (rst) begin
      sysref_mode <= `SCS_RST_SR_MODE;
    end else if (wr_ctrl1) begin
      sysref_mode <= writedata[`SCS_CTRL1_MODE_HI:`SCS_CTRL1_MODE_LO];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      ts_delay_reg <= `SCS_RST_TS_DELAY;
    end else if (wr_ts_delay) begin
      ts_delay_reg <= writedata[6:0];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      sync_mode_reg <= `SCS_RST_SYNC_MODE;
    end else if (wr_sync_mode) begin
      sync_mode_reg <= writedata[`SCS_SYNC_MODE_BIT];
    end
  end

  // Bit 4 is reserved and held at zero; 7:6 stay read/write
  always @(posedge clk) begin
    if (rst) begin
      op_mode_reg <= `SCS_RST_OP_MODE;
    end else if (wr_op_mode) begin
      op_mode_reg <= {writedata[7:5], 1'b0, writedata[3:0]};
    end
  end

  // Capture bookkeeping
  always @* begin
    phase_next = phase_reg;
    count_next = count_step(count_reg, sysref_capture, clr_cnt);
    if (sysref_capture)
      phase_next = div_phase;
  end

  always @(posedge clk) begin
    if (rst) begin
      phase_reg <= `SCS_RST_PHASE;
      count_reg <= `SCS_RST_COUNT;
    end else if (ce) begin
      phase_reg <= phase_next;
      count_reg <= count_next;
    end
  end

  // Divider reset and monitor realignment
  always @(posedge clk) begin
    if (rst) begin
      div_reset <= 1'b0;
      mon_sync  <= 1'b0;
    end else if (ce) begin
      div_reset <= sysref_capture & reset_mode;
      mon_sync  <= sysref_capture & reset_mode;
    end
  end

  // Nonzero phase means the divider has to jump
  always @(posedge clk) begin
    if (rst) begin
      link_drop <= 1'b0;
    end else if (ce) begin
      link_drop <= sysref_capture & reset_mode & phase_moved;
    end
  end

  // Timestamp delay line, one stage per sample clock
  always @(posedge clk) begin
    if (rst)
      mark_line_reg <= {DLY_LEN{1'b0}};
    else if (ce)
      mark_line_reg <= {mark_line_reg[DLY_LEN-2:0], ts_event};
  end

  // Output word, I and valid
  always @(posedge clk) begin
    if (rst) begin
      out_i     <= {DATA_W{1'b0}};
      out_valid <= 1'b0;
    end else if (ce) begin
      out_i     <= in_i;
      out_valid <= in_valid;
    end
  end

  // Q is zeroed, not held, so stale data never leaks out
  always @(posedge clk) begin
    if (rst) begin
      out_q    <= {DATA_W{1'b0}};
      out_q_en <= 1'b1;
    end else if (ce) begin
      out_q    <= op_mode_reg[`SCS_OP_IONLY_BIT] ? {DATA_W{1'b0}} : in_q;
      out_q_en <= ~op_mode_reg[`SCS_OP_IONLY_BIT];
    end
  end

  // Timestamp control bit
  always @(posedge clk) begin
    if (rst)
      out_ts_mark <= 1'b0;
    else if (ce)
      out_ts_mark <= ts_tap;
  end

endmodule

// ==== verilog/scs_map.vh ====
`ifndef SCS_MAP_VH
`define SCS_MAP_VH

// Register indices; byte address is four times the index
`define SCS_IDX_CTRL1       10'h120
`define SCS_IDX_TS_DELAY    10'h123
`define SCS_IDX_PHASE       10'h129
`define SCS_IDX_COUNT       10'h12A
`define SCS_IDX_SYNC_MODE   10'h1FF
`define SCS_IDX_OP_MODE     10'h200

// Field positions
`define SCS_CTRL1_CLR_BIT   6
`define SCS_CTRL1_MODE_HI   2
`define SCS_CTRL1_MODE_LO   1
`define SCS_SYNC_MODE_BIT   0
`define SCS_OP_IONLY_BIT    5
`define SCS_OP_RSV_BIT      4
`define SCS_OP_APP_HI       3
`define SCS_OP_APP_LO       0

// Mode-select code meaning disabled
`define SCS_SR_MODE_OFF     2'h0

// Reset values
`define SCS_RST_CTRL1       8'h00
`define SCS_RST_SR_MODE     2'h0
`define SCS_RST_TS_DELAY    7'h00
`define SCS_RST_PHASE       4'h0
`define SCS_RST_COUNT       8'h00
`define SCS_RST_SYNC_MODE   1'h0
`define SCS_RST_OP_MODE     8'h00

// Timing
`define SCS_CLK_PERIOD_NS   5
`define SCS_TS_DELAY_MAX    127
`define SCS_BUS_WAIT_CYC    1

`endif

// ==== tb/scs_sref_gen.sv ====
module scs_sref_gen (
  input  wire        clk,            // Sample clock
  output logic       sysref_capture, // Capture pulse
  output logic [3:0] div_phase       // Phase with pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sysref_capture = 1'b0;
    div_phase = 4'h0;
  end
  // Pulses spaced by two idle cycles; phase scrambled once the pulse is gone
  task automatic fire(input logic [3:0] ph);
    repeat (2) @(posedge clk);
    sysref_capture <= 1'b1;
    div_phase <= ph;
    @(posedge clk);
    sysref_capture <= 1'b0;
    div_phase <= ~ph;
  endtask
endmodule

// ==== tb/scs_sysref_sync_assertions.sv ====
module scs_sysref_sync_assertions (
  input wire        clk,            // Clock
  input wire        rst,            // Reset
  input wire        sysref_capture, // Capture
  input wire [3:0]  div_phase,      // Phase
  input wire [13:0] in_i,           // I in
  input wire [13:0] in_q,           // Q in
  input wire        in_valid,       // Valid in
  input wire [13:0] out_i,          // I out
  input wire [13:0] out_q,          // Q out
  input wire        out_q_en,       // Q present
  input wire        out_valid,      // Valid out
  input wire        out_ts_mark,    // Mark
  input wire        div_reset,      // Divider reset
  input wire        link_drop,      // Link drop
  input wire        mon_sync        // Monitor sync
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] since_reg;
  always @(posedge clk) begin
    if (rst)
      since_reg <= 8'hFF;
    else if (sysref_capture)
      since_reg <= 8'h00;
    else if (since_reg != 8'hFF)
      since_reg <= since_reg + 8'h01;
  end
  sequence s_cap_moved;
    (sysref_capture && div_phase != 4'h0) ##1 div_reset;
  endsequence
  a_reset_cause: assert property (div_reset |-> $past(sysref_capture) && mon_sync)
    else $error("divider reset without capture");
  a_reset_pulse: assert property (div_reset |=> !div_reset)
    else $error("divider reset too long");
  a_drop_cause: assert property (link_drop |-> div_reset && $past(div_phase) != 4'h0)
    else $error("link drop without phase move");
  a_drop_follow: assert property (s_cap_moved |-> link_drop)
    else $error("link kept after phase move");
  a_drop_still: assert property (sysref_capture && div_phase == 4'h0 |=> !link_drop)
    else $error("link dropped in phase");
  a_data_i: assert property (in_valid |=> out_valid && out_i == $past(in_i))
    else $error("I sample wrong");
  a_q_pass: assert property (out_valid && out_q_en |-> out_q == $past(in_q))
    else $error("Q sample wrong");
  a_q_drop: assert property (!out_q_en |-> out_q == 14'h0000)
    else $error("Q not discarded");
  a_ts_window: assert property (out_ts_mark |-> since_reg <= 8'h7F)
    else $error("mark outside delay window");
endmodule
bind scs_sysref_sync scs_sysref_sync_assertions u_chk (.*);

// ==== tb/scs_sysref_sync_tb.sv ====
module scs_sysref_sync_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] address = 12'h000;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [13:0] in_i = 14'h2A5C;
  logic [13:0] in_q = 14'h13C7;
  logic        in_valid = 1'b1;
  logic        ce = 1'b1;
  logic [3:0]  byteenable = 4'hF;
  logic [31:0] d;
  wire  [31:0] readdata;
  wire         waitrequest, sysref_capture, out_q_en, out_valid, out_ts_mark, div_reset, link_drop, mon_sync;
  wire  [3:0]  div_phase;
  wire  [13:0] out_i, out_q;
  wire  [1:0]  sysref_mode;
  int          fail_count = 0, samples_checked = 0, resets_seen = 0, k;
  logic [9:0]  idx_tab [6] = '{10'h120, 10'h123, 10'h129, 10'h12A, 10'h1FF, 10'h200};
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (div_reset === 1'b1)
      resets_seen <= resets_seen + 1;
  end
  scs_sysref_sync u_scs_sysref_sync (.*);
  scs_sref_gen u_sref_gen (.*);
  task automatic conclude;
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Waitrequest and read data are seen at the edge itself, before it updates them
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    address <= {idx, 2'h0};
    read <= !wr;
    write <= wr;
    writedata <= {24'h0, wd};
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      fail_count++;
      conclude();
    end
    d = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [9:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(what, exp, d);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int j = 0; j < 6; j++)
      rdchk("reset value", idx_tab[j], 32'h0);
    bus(1'b1, 10'h1FF, 8'hFF);
    rdchk("sync mode", 10'h1FF, 32'h01);
    bus(1'b1, 10'h200, 8'hFF);
    rdchk("chip mode", 10'h200, 32'hEF);
    bus(1'b1, 10'h3FF, 8'h55);
    rdchk("unmapped", 10'h3FF, 32'h0);
    chk("q dropped", 32'h0, {out_q_en, out_q});
    bus(1'b1, 10'h120, 8'h04);
    @(posedge clk);
    chk("mode field", 32'h2, sysref_mode);
    bus(1'b1, 10'h120, 8'h00);
    bus(1'b1, 10'h200, 8'h00);
    bus(1'b1, 10'h1FF, 8'h00); // Divider reset mode for aligned devices
    chk("q kept", {out_q_en, out_q}, {1'b1, in_q});
    for (int p = 0; p < 16; p++) begin
      u_sref_gen.fire(p[3:0]);
      rdchk("capture phase", 10'h129, p);
    end
    chk("divider resets", resets_seen, 16);
    rdchk("event count", 10'h12A, 32'h10);
    repeat (240) u_sref_gen.fire(4'h0);
    rdchk("count wrap", 10'h12A, 32'h0);
    u_sref_gen.fire(4'h9);
    bus(1'b1, 10'h120, 8'h40);
    rdchk("count clear", 10'h12A, 32'h0);
    rdchk("clear bit", 10'h120, 32'h0);
    ce <= 1'b0;
    u_sref_gen.fire(4'h3);
    ce <= 1'b1;
    rdchk("frozen count", 10'h12A, 32'h0);
    bus(1'b1, 10'h123, 8'h85);
    rdchk("ts delay", 10'h123, 32'h05);
    byteenable <= 4'h0;
    bus(1'b1, 10'h123, 8'h11);
    byteenable <= 4'hF;
    rdchk("masked write", 10'h123, 32'h05);
    bus(1'b1, 10'h1FF, 8'h01);
    u_sref_gen.fire(4'h2);
    k = 1;
    #1;
    while (out_ts_mark !== 1'b1 && k < 300) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("ts mark delay", k, 6);
    chk("divider resets", resets_seen, 257);
    conclude();
  end
endmodule
